// File: parallel_host_message_port.sv
/*
  Device side of an 8-bit parallel host port with separate read and
  write strobes, four registers by a 2-bit select, two audio input
  buffers and an active-low message request line.
  Assumes host pins are asynchronous to mclk and that strobe phases
  each last at least three mclk periods.
*/
// Overview of operation
// - Select 00 message, 01 control/status, 10 linear PCM, 11 compressed.
// - Message register is two bytes: inbound written by host, outbound read.
// - Bit 2 host_input_pending set by host write, cleared by DSP read.
// - Bit 1 host_output_pending set by DSP write, cleared by host read.
// - Bit 6 write-only; one holds compressed channel in reset, zero releases.
// - Bit 5 write-only; one holds linear channel in reset, zero releases.
// - Bit 4 reads high while linear buffer is almost full.
// - Bit 3 reads high while compressed buffer is almost full.
// - Bytes written at select 10 enter the linear PCM buffer.
// - Bytes written at select 11 enter the compressed buffer.
// - Host read: select, strobes low, device drives data, strobes high.
// - With notification enabled, request line mirrors host_output_pending.
// - Almost-full flags set when buffer level reaches its threshold.
// - Request line is active low and silent during boot handshake.
`timescale 1ns/1ps
module parallel_host_message_port #(
  parameter int DEPTH  = host_port_pkg::DEF_DEPTH,
  parameter int THRESH = host_port_pkg::DEF_THRESH
) (
  // Clock and reset
  input  wire logic       mclk,
  input  wire logic       rst,
  // Host pins
  input  wire logic [1:0] regSelect,
  input  wire logic       portSelect_n,
  input  wire logic       writeStrobe_n,
  input  wire logic       readStrobe_n,
  input  wire logic [7:0] dataIn,
  output logic      [7:0] dataOut,
  output logic            dataOe,
  output logic            messageRequest_n,
  // DSP side
  input  wire logic       notifyEnable,
  input  wire logic       bootMode,
  input  wire logic       dspOutWrite,
  input  wire logic [7:0] dspOutData,
  input  wire logic       dspInRead,
  output logic      [7:0] dspInData,
  output logic            hostInputPending,
  output logic            hostOutputPending,
  input  wire logic       linPop,
  output logic      [7:0] linData,
  output logic            linValid,
  output logic            linChannelReset,
  input  wire logic       cmpPop,
  output logic      [7:0] compressed_input_port,
  output logic            cmpValid,
  output logic            cmpChannelReset
);
  import host_port_pkg::*;
  localparam int AW = $clog2(DEPTH);

  // Two-stage synchronisers; first stage read only by second
  logic [2:0] strbMeta_q, strbSync_q, strbLast_q;
  logic [1:0] selMeta_q, selSync_q;
  logic [7:0] datMeta_q, datSync_q;
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      strbMeta_q <= 3'h7;
      strbSync_q <= 3'h7;
      strbLast_q <= 3'h7;
      selMeta_q  <= 2'h0;
      selSync_q  <= 2'h0;
      datMeta_q  <= BYTE_ZERO;
      datSync_q  <= BYTE_ZERO;
    end else begin
      strbMeta_q <= {portSelect_n, writeStrobe_n, readStrobe_n};
      strbSync_q <= strbMeta_q;
      strbLast_q <= strbSync_q;
      selMeta_q  <= regSelect;
      selSync_q  <= selMeta_q;
      datMeta_q  <= dataIn;
      datSync_q  <= datMeta_q;
    end
  end

  // Cycle active = port select and a strobe low; events on its release
  logic wrActive, wrActiveLast, rdActive, rdActiveLast, wrEnd, rdEnd;
  assign wrActive     = !strbSync_q[2] && !strbSync_q[1];
  assign wrActiveLast = !strbLast_q[2] && !strbLast_q[1];
  assign rdActive     = !strbSync_q[2] && !strbSync_q[0];
  assign rdActiveLast = !strbLast_q[2] && !strbLast_q[0];
  assign wrEnd = wrActiveLast && !wrActive;
  assign rdEnd = rdActiveLast && !rdActive;

  // Data held while strobe low, so the registered copy is stable
  logic [7:0] wrByte_q;
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) wrByte_q <= BYTE_ZERO;
    else if (wrActive) wrByte_q <= datSync_q;
  end

  logic wrMsg, wrCtl, wrLin, wrCmp, rdMsg;
  assign wrMsg = wrEnd && selSync_q == SEL_MESSAGE;
  assign wrCtl = wrEnd && selSync_q == SEL_CONTROL;
  assign wrLin = wrEnd && selSync_q == SEL_PCM;
  assign wrCmp = wrEnd && selSync_q == SEL_COMPRESSED;
  assign rdMsg = rdEnd && selSync_q == SEL_MESSAGE;

  // Separate inbound and outbound bytes
  logic [7:0] inMsg_q, outMsg_q;
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      inMsg_q  <= BYTE_ZERO;
      outMsg_q <= BYTE_ZERO;
    end else begin
      if (wrMsg) inMsg_q <= wrByte_q;
      if (dspOutWrite) outMsg_q <= dspOutData;
    end
  end
  assign dspInData = inMsg_q;

  // Handshake flags; a set in the clearing cycle wins
  logic inPend_q, outPend_q;
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      inPend_q  <= 1'h0;
      outPend_q <= 1'h0;
    end else begin
      if (wrMsg) inPend_q <= 1'h1;
      else if (dspInRead) inPend_q <= 1'h0;
      if (dspOutWrite) outPend_q <= 1'h1;
      else if (rdMsg) outPend_q <= 1'h0;
    end
  end
  assign hostInputPending  = inPend_q;
  assign hostOutputPending = outPend_q;

  // Channel reset bits; reserved bits written are ignored
  logic linRst_q, compressed_channel_reset_q;
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      linRst_q <= 1'h0;
      compressed_channel_reset_q <= 1'h0;
    end else if (wrCtl) begin
      linRst_q <= wrByte_q[BIT_LIN_RST];
      compressed_channel_reset_q <= wrByte_q[BIT_CMP_RST];
    end
  end
  assign linChannelReset = linRst_q;
  assign cmpChannelReset = compressed_channel_reset_q;

  // Input buffers; a byte arriving when full is dropped, host paces on flags
  logic [7:0] bufMem_q [2][DEPTH];
  logic [AW-1:0] wp_q [2];
  logic [AW-1:0] rp_q [2];
  logic [AW:0]   lvl_q [2];
  logic [1:0]    nearFull_q;
  logic [1:0]    push, pop, chRst;
  assign push  = {wrCmp, wrLin};
  assign pop   = {cmpPop, linPop};
  assign chRst = {compressed_channel_reset_q, linRst_q};
  for (genvar c = 0; c < 2; c++) begin : g_buf
    logic doPush, doPop;
    assign doPush = push[c] && lvl_q[c] != (AW+1)'(DEPTH);
    assign doPop  = pop[c] && lvl_q[c] != '0;
    always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
        wp_q[c]  <= '0;
        rp_q[c]  <= '0;
        lvl_q[c] <= '0;
      end else if (chRst[c]) begin
        wp_q[c]  <= '0;
        rp_q[c]  <= '0;
        lvl_q[c] <= '0;
      end else begin
        if (doPush) wp_q[c] <= AW'((wp_q[c] + 1'b1) % DEPTH);
        if (doPop) rp_q[c] <= AW'((rp_q[c] + 1'b1) % DEPTH);
        lvl_q[c] <= lvl_q[c] + (AW+1)'(doPush) - (AW+1)'(doPop);
      end
    end
    always_ff @(posedge mclk) begin
      if (doPush && !chRst[c]) bufMem_q[c][wp_q[c]] <= wrByte_q;
    end
    always_ff @(posedge mclk or posedge rst) begin
      if (rst) nearFull_q[c] <= 1'h0;
      else nearFull_q[c] <= lvl_q[c] >= (AW+1)'(THRESH);
    end
  end
  assign linData  = bufMem_q[0][rp_q[0]];
  assign compressed_input_port  = bufMem_q[1][rp_q[1]];
  assign linValid = lvl_q[0] != '0;
  assign cmpValid = lvl_q[1] != '0;

  // Read data and enable; audio ports read as zero and are not driven
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      dataOut <= BYTE_ZERO;
      dataOe  <= 1'h0;
    end else begin
      dataOe <= rdActive && !selSync_q[1];
      dataOut <= BYTE_ZERO;
      case (selSync_q)
        SEL_MESSAGE: dataOut <= outMsg_q;
        SEL_CONTROL: begin
          dataOut[BIT_LIN_FULL] <= nearFull_q[0];
          dataOut[BIT_CMP_FULL] <= nearFull_q[1];
          dataOut[BIT_IN_PEND]  <= inPend_q;
          dataOut[BIT_OUT_PEND] <= outPend_q;
        end
        default: dataOut <= BYTE_ZERO;
      endcase
    end
  end

  // Request line, active low; held idle in boot
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) messageRequest_n <= LINE_IDLE;
    else messageRequest_n <= !(notifyEnable && !bootMode && outPend_q);
  end

  pend_set_a: assert property (@(posedge mclk) disable iff (rst)
    wrMsg |=> inPend_q) else $error("input pending not set");
  pend_out_a: assert property (@(posedge mclk) disable iff (rst)
    dspOutWrite |=> outPend_q) else $error("output pending not set");
  out_clear_a: assert property (@(posedge mclk) disable iff (rst)
    rdMsg && !dspOutWrite |=> !outPend_q) else $error("output pending not cleared");
  req_mirror_a: assert property (@(posedge mclk) disable iff (rst)
    notifyEnable && !bootMode && outPend_q |=> !messageRequest_n) else $error("request not low");
  req_boot_a: assert property (@(posedge mclk) disable iff (rst)
    bootMode |=> messageRequest_n) else $error("request in boot");
  oe_read_a: assert property (@(posedge mclk) disable iff (rst)
    dataOe |-> $past(rdActive && !selSync_q[1])) else $error("drive outside read");
  lin_rst_a: assert property (@(posedge mclk) disable iff (rst)
    linRst_q |=> lvl_q[0] == '0) else $error("linear buffer not held");
  cmp_rst_a: assert property (@(posedge mclk) disable iff (rst)
    compressed_channel_reset_q |=> lvl_q[1] == '0) else $error("compressed buffer not held");
  full_flag_a: assert property (@(posedge mclk) disable iff (rst)
    lvl_q[0] >= (AW+1)'(THRESH) |=> nearFull_q[0]) else $error("almost full missed");
  lin_push_a: assert property (@(posedge mclk) disable iff (rst)
    wrLin && !linRst_q && lvl_q[0] == '0 && !linPop |=> lvl_q[0] == (AW+1)'(1))
    else $error("linear byte lost");

  msg_write_c: cover property (@(posedge mclk) disable iff (rst) wrMsg ##[1:20] dspInRead);
  msg_read_c:  cover property (@(posedge mclk) disable iff (rst) dspOutWrite ##[1:40] rdMsg);
  lin_full_c:  cover property (@(posedge mclk) disable iff (rst) nearFull_q[0]);
  cmp_full_c:  cover property (@(posedge mclk) disable iff (rst) nearFull_q[1]);
endmodule : parallel_host_message_port

// File: host_port_pkg.sv
/*
  Constants for the parallel host message port: register selects,
  control/status bit positions, reset values and buffer defaults.
  Assumes nothing of its surroundings.
*/
package host_port_pkg;
  localparam logic [1:0] SEL_MESSAGE    = 2'h0;
  localparam logic [1:0] SEL_CONTROL    = 2'h1;
  localparam logic [1:0] SEL_PCM        = 2'h2;
  localparam logic [1:0] SEL_COMPRESSED = 2'h3;

  localparam int BIT_CMP_RST  = 6;
  localparam int BIT_LIN_RST  = 5;
  localparam int BIT_LIN_FULL = 4;
  localparam int BIT_CMP_FULL = 3;
  localparam int BIT_IN_PEND  = 2;
  localparam int BIT_OUT_PEND = 1;

  localparam logic [7:0] BYTE_ZERO  = 8'h00;
  localparam logic       LINE_IDLE  = 1'h1;
  localparam int         DEF_DEPTH  = 16;
  localparam int         DEF_THRESH = 12;
endpackage : host_port_pkg

// File: host_bus_model.sv
/*
  Host partner: drives the separate-strobe parallel bus, one byte a cycle.
  Assumes mclk of the port and strobe phases of at least three mclk.
*/
`timescale 1ns/1ps
module host_bus_model (
  // Clock
  input  wire logic       mclk,
  // Host pins
  output logic      [1:0] regSelect,
  output logic            portSelect_n,
  output logic            writeStrobe_n,
  output logic            readStrobe_n,
  output logic      [7:0] dataIn,
  // Read answer
  input  wire logic [7:0] dataOut,
  input  wire logic       dataOe
);
  initial begin
    regSelect = 2'h0;
    {portSelect_n, writeStrobe_n, readStrobe_n} = 3'h7;
    dataIn = 8'h00;
  end
  // Select first, strobes held five edges, then select held past release
  task automatic access(input logic [1:0] sel, input logic wr, input logic [7:0] wd,
                        output logic [7:0] rd, output logic oe);
    @(posedge mclk) #1 regSelect = sel;
    dataIn = wr ? wd : ~dataIn;
    // Only the strobe of this cycle's kind goes low; the other stays high
    @(posedge mclk) #1 {portSelect_n, writeStrobe_n, readStrobe_n} = {1'h0, !wr, wr};
    repeat (5) @(posedge mclk);
    #1 rd = dataOut;
    oe = dataOe;
    {portSelect_n, writeStrobe_n, readStrobe_n} = 3'h7;
    repeat (4) @(posedge mclk);
    // Released data lines must not keep the old byte
    #1 dataIn = ~dataIn;
    repeat (3) @(posedge mclk);
  endtask : access
endmodule : host_bus_model

// File: parallel_host_message_port_bench.sv
/*
  Bench for the parallel host message port: queue model compared at every result.
  Assumes the host partner model and the port package.
*/
`timescale 1ns/1ps
module parallel_host_message_port_bench;
  import host_port_pkg::*;
  localparam int DEPTH = 8;
  localparam int THRESH = 4;
  // Control bytes: linear, compressed, both, none held in reset; reserved bits zero
  localparam logic [31:0] CTL_SEQ = 32'h20406000;
  logic       mclk, rst, notifyEnable, bootMode, dspOutWrite, dspInRead, linPop, cmpPop;
  logic [7:0] dspOutData, dataOut, dspInData, linData, compressed_input_port, dataIn, rd, d;
  logic [1:0] regSelect;
  logic       portSelect_n, writeStrobe_n, readStrobe_n, dataOe, messageRequest_n, oe;
  logic       hostInputPending, hostOutputPending, linValid, linChannelReset, cmpValid, cmpChannelReset;
  int         bad_count, compares, cycles, seed, inPend, outPend;
  logic [7:0] bufQ [2][$];

  host_bus_model u_host_bus_model (.mclk(mclk), .regSelect(regSelect), .portSelect_n(portSelect_n),
    .writeStrobe_n(writeStrobe_n), .readStrobe_n(readStrobe_n), .dataIn(dataIn), .dataOut(dataOut),
    .dataOe(dataOe));
  parallel_host_message_port #(.DEPTH(DEPTH), .THRESH(THRESH)) u_parallel_host_message_port (
    .mclk(mclk), .rst(rst), .regSelect(regSelect), .portSelect_n(portSelect_n),
    .writeStrobe_n(writeStrobe_n), .readStrobe_n(readStrobe_n), .dataIn(dataIn), .dataOut(dataOut),
    .dataOe(dataOe), .messageRequest_n(messageRequest_n), .notifyEnable(notifyEnable), .bootMode(bootMode),
    .dspOutWrite(dspOutWrite), .dspOutData(dspOutData), .dspInRead(dspInRead), .dspInData(dspInData),
    .hostInputPending(hostInputPending), .hostOutputPending(hostOutputPending), .linPop(linPop),
    .linData(linData), .linValid(linValid), .linChannelReset(linChannelReset), .cmpPop(cmpPop),
    .compressed_input_port(compressed_input_port), .cmpValid(cmpValid), .cmpChannelReset(cmpChannelReset));

  initial begin
    mclk = 1'h0;
    forever #20 mclk = ~mclk;
  end

  task automatic complete_run;
    $display("compares %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : complete_run

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  // Control byte as the model sees it; reset bits read back zero
  task automatic readCtl;
    logic [7:0] e;
    e = 8'h00;
    e[BIT_LIN_FULL] = bufQ[0].size() >= THRESH;
    e[BIT_CMP_FULL] = bufQ[1].size() >= THRESH;
    e[BIT_IN_PEND] = inPend != 0;
    e[BIT_OUT_PEND] = outPend != 0;
    u_host_bus_model.access(SEL_CONTROL, 1'h0, 8'h00, rd, oe);
    check(rd, e);
    check({7'h0, oe}, 8'h01);
    check({6'h0, hostInputPending, hostOutputPending}, {6'h0, e[BIT_IN_PEND], e[BIT_OUT_PEND]});
  endtask : readCtl

  always @(posedge mclk) begin
    cycles++;
    if (cycles > 5000) begin
      bad_count++;
      complete_run();
    end
  end

  initial begin
    {notifyEnable, bootMode, dspOutWrite, dspInRead, linPop, cmpPop} = 6'h00;
    dspOutData = 8'h00;
    rst = 1'h1;
    seed = 45132;
    repeat (16) @(posedge mclk);
    #1 rst = 1'h0;
    check({7'h0, messageRequest_n}, 8'h01);
    readCtl();
    // Inbound message byte, then the DSP consumes it
    d = $random(seed);
    u_host_bus_model.access(SEL_MESSAGE, 1'h1, d, rd, oe);
    inPend = 1;
    readCtl();
    check(dspInData, d);
    @(posedge mclk) #1 dspInRead = 1'h1;
    @(posedge mclk) #1 dspInRead = 1'h0;
    inPend = 0;
    readCtl();
    // Outbound byte with and without boot suppression
    for (int b = 1; b >= 0; b--) begin
      d = $random(seed);
      #1 {notifyEnable, bootMode, dspOutData} = {1'h1, b[0], d};
      @(posedge mclk) #1 dspOutWrite = 1'h1;
      @(posedge mclk) #1 dspOutWrite = 1'h0;
      outPend = 1;
      repeat (2) @(posedge mclk);
      #1 check({7'h0, messageRequest_n}, {7'h0, b[0]});
      readCtl();
      u_host_bus_model.access(SEL_MESSAGE, 1'h0, 8'h00, rd, oe);
      check(rd, d);
      outPend = 0;
      readCtl();
      check({7'h0, messageRequest_n}, 8'h01);
    end
    // Fill each audio buffer past its threshold, refuse a read, drain in order
    for (int ch = 0; ch < 2; ch++) begin
      for (int i = 0; i <= THRESH; i++) begin
        d = $random(seed);
        u_host_bus_model.access(ch ? SEL_COMPRESSED : SEL_PCM, 1'h1, d, rd, oe);
        bufQ[ch].push_back(d);
        readCtl();
      end
      u_host_bus_model.access(ch ? SEL_COMPRESSED : SEL_PCM, 1'h0, 8'h00, rd, oe);
      check({7'h0, oe}, 8'h00);
      while (bufQ[ch].size() > 0) begin
        check(ch ? compressed_input_port : linData, bufQ[ch].pop_front());
        check({7'h0, ch ? cmpValid : linValid}, 8'h01);
        @(posedge mclk) #1 {cmpPop, linPop} = ch ? 2'h2 : 2'h1;
        @(posedge mclk) #1 {cmpPop, linPop} = 2'h0;
        repeat (2) @(posedge mclk);
        #1;
      end
      check({7'h0, ch ? cmpValid : linValid}, 8'h00);
      readCtl();
    end
    // Channel reset bits held and released
    for (int i = 0; i < 4; i++) begin
      d = CTL_SEQ[8*(3-i) +: 8];
      u_host_bus_model.access(SEL_CONTROL, 1'h1, d, rd, oe);
      check({6'h0, cmpChannelReset, linChannelReset}, {6'h0, d[BIT_CMP_RST], d[BIT_LIN_RST]});
    end
    complete_run();
  end
endmodule : parallel_host_message_port_bench
